// file: core/uvc_host.sv
// host controller that reads, identifies and programs a uv eprom
`timescale 1ns/100ps
`include "uvc_defines.svh"
module uvc_host #(
  parameter int ADDR_W = 18,
  parameter int SETUP_CYC = `UVC_SETUP_CYC,
  parameter int PULSE_CYC = `UVC_PULSE_CYC,
  parameter int ACC_CYC = `UVC_ACC_CYC,
  parameter int MAX_PULSES = `UVC_MAX_PULSES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire uvc_pkg::uvc_cmd_e cmd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic fail,
  output logic [7:0] rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic program_strobe_n,
  output logic prog_supply_hi,
  output logic id_highvolt_addr_line,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n
);
  import uvc_pkg::*;

  localparam int CNT_W = $clog2(PULSE_CYC + SETUP_CYC + ACC_CYC + 2);
  // the verify gate must fall within the data hold after each pulse
  localparam int VERIFY_WAIT = SETUP_CYC + 1;

  // refuse settings the counters cannot hold; tries_r is four bits wide
  if (ADDR_W < 1 || SETUP_CYC < 1 || PULSE_CYC < 1 || ACC_CYC < 1 ||
      MAX_PULSES < 1 || MAX_PULSES > 15) begin : g_bad_param
    $error("uvc_host: unsupported parameter values");
  end

  uvc_state_e state_r;
  uvc_cmd_e cmd_r;
  logic [7:0] wdata_r;
  logic [CNT_W-1:0] cnt_r;
  logic [3:0] tries_r;
  logic cnt_zero;

  assign cnt_zero = (cnt_r == '0);

  // sequencer: setup, pulse, gap, verify loop for programming
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= UVC_IDLE;
      cmd_r <= UVC_CMD_READ;
      wdata_r <= 8'h00;
      cnt_r <= '0;
      tries_r <= 4'h0;
    end else begin
      unique case (state_r)
        UVC_IDLE: begin
          if (req) begin
            cmd_r <= cmd;
            wdata_r <= wdata;
            tries_r <= 4'h0;
            cnt_r <= CNT_W'(SETUP_CYC - 1);
            state_r <= UVC_SETUP;
          end
        end
        UVC_SETUP: begin
          if (!cnt_zero) cnt_r <= cnt_r - 1'b1;
          else if (cmd_r == UVC_CMD_PROG) begin
            cnt_r <= CNT_W'(PULSE_CYC - 1); // RULE11
            tries_r <= tries_r + 4'h1;
            state_r <= UVC_PULSE;
          end else begin
            cnt_r <= CNT_W'(ACC_CYC); // RULE2 RULE3
            state_r <= UVC_READ;
          end
        end
        UVC_READ: begin
          if (!cnt_zero) cnt_r <= cnt_r - 1'b1;
          else state_r <= UVC_DONE;
        end
        UVC_PULSE: begin
          if (!cnt_zero) cnt_r <= cnt_r - 1'b1;
          else begin
            cnt_r <= CNT_W'(SETUP_CYC - 1); // RULE13
            state_r <= UVC_GAP;
          end
        end
        UVC_GAP: begin
          if (!cnt_zero) cnt_r <= cnt_r - 1'b1;
          else begin
            cnt_r <= CNT_W'(ACC_CYC);
            state_r <= UVC_VERIFY;
          end
        end
        UVC_VERIFY: begin
          if (!cnt_zero) cnt_r <= cnt_r - 1'b1;
          else if (data_in == wdata_r || tries_r == 4'(MAX_PULSES))
            state_r <= UVC_DONE; // RULE12 RULE17
          else begin
            cnt_r <= CNT_W'(SETUP_CYC - 1);
            state_r <= UVC_SETUP;
          end
        end
        UVC_DONE: state_r <= UVC_IDLE;
        default: state_r <= UVC_IDLE;
      endcase
    end
  end

  // pin drive; gate stays high through programming so the part takes data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      program_strobe_n <= 1'b1;
      prog_supply_hi <= 1'b0;
      id_highvolt_addr_line <= 1'b0;
      data_oe_n <= 1'b1;
      data_out <= 8'h00;
      mem_addr <= '0;
    end else begin
      if (state_r == UVC_IDLE && req) begin
        mem_addr <= addr;
        data_out <= wdata; // RULE10
        prog_supply_hi <= (cmd == UVC_CMD_PROG); // RULE9 RULE19
        id_highvolt_addr_line <= (cmd == UVC_CMD_ID); // RULE18
        // one select line; parts sharing the other pins each get their own
        chip_select_n <= 1'b0; // RULE6 RULE15
      end
      if (state_r == UVC_DONE) begin
        chip_select_n <= 1'b1; // RULE4
        prog_supply_hi <= 1'b0;
        id_highvolt_addr_line <= 1'b0;
      end
      // strobe low only for the timed pulse, never static
      program_strobe_n <= !(state_r == UVC_PULSE && !cnt_zero) &&
                          !(state_r == UVC_SETUP && cnt_zero &&
                            cmd_r == UVC_CMD_PROG); // RULE11 RULE13 RULE14
      // data driven only while gate is high in program mode
      data_oe_n <= !((state_r == UVC_IDLE && req && cmd == UVC_CMD_PROG) ||
                     (cmd_r == UVC_CMD_PROG &&
                      (state_r == UVC_SETUP || state_r == UVC_PULSE ||
                       (state_r == UVC_GAP && !cnt_zero)))); // RULE10
      output_gate_n <= !((state_r == UVC_SETUP && cnt_zero &&
                          cmd_r != UVC_CMD_PROG) || state_r == UVC_READ ||
                         (state_r == UVC_GAP && cnt_zero) ||
                         (state_r == UVC_VERIFY && !cnt_zero)); // RULE1 RULE5
    end
  end

  // results, captured at the end of the access window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      done <= 1'b0;
      fail <= 1'b0;
      busy <= 1'b0;
    end else begin
      done <= 1'b0;
      busy <= (state_r != UVC_IDLE) || req;
      if ((state_r == UVC_READ || state_r == UVC_VERIFY) && cnt_zero)
        rdata <= data_in; // RULE8
      if (state_r == UVC_VERIFY && cnt_zero &&
          (data_in == wdata_r || tries_r == 4'(MAX_PULSES))) begin
        done <= 1'b1;
        fail <= (data_in != wdata_r);
      end else if (state_r == UVC_READ && cnt_zero) begin
        done <= 1'b1;
        fail <= 1'b0;
      end
    end
  end

  // strobe low lasts at least four cycles once it falls
  sequence strobe_fall_s;
    $fell(program_strobe_n);
  endsequence
  strobe_width_a: assert property (@(posedge clk) disable iff (rst)
    strobe_fall_s |-> !program_strobe_n [*4]) // RULE13
    else $error("program strobe pulse too short");
  strobe_gate_a: assert property (@(posedge clk) disable iff (rst)
    !program_strobe_n |-> output_gate_n && prog_supply_hi &&
      !chip_select_n) // RULE9
    else $error("strobe low outside program mode");
  drive_gate_a: assert property (@(posedge clk) disable iff (rst)
    !data_oe_n |-> output_gate_n) // RULE10
    else $error("host drives data while gate low");
  tries_cap_a: assert property (@(posedge clk) disable iff (rst)
    tries_r <= 4'(MAX_PULSES)) // RULE12
    else $error("too many program pulses");
  verify_ctl_a: assert property (@(posedge clk) disable iff (rst)
    state_r == UVC_VERIFY && cnt_zero |-> !output_gate_n &&
      program_strobe_n && !chip_select_n) // RULE17
    else $error("verify controls wrong");
  idle_float_a: assert property (@(posedge clk) disable iff (rst)
    $rose(done) |=> chip_select_n && !prog_supply_hi) // RULE4
    else $error("part still selected after done");
  read_gate_a: assert property (@(posedge clk) disable iff (rst)
    state_r == UVC_READ |-> !output_gate_n && !chip_select_n) // RULE1
    else $error("read without select and gate");
  id_line_a: assert property (@(posedge clk) disable iff (rst)
    id_highvolt_addr_line |-> !prog_supply_hi) // RULE18
    else $error("id line high in program mode");

  // helper for the width check: cycles the strobe has been low so far
  logic [CNT_W-1:0] low_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) low_cnt_r <= '0;
    else if (!program_strobe_n) low_cnt_r <= low_cnt_r + 1'b1;
    else low_cnt_r <= '0;
  end

  strobe_exact_a: assert property (@(posedge clk) disable iff (rst)
    $rose(program_strobe_n) |-> low_cnt_r == CNT_W'(PULSE_CYC)) // RULE12
    else $error("program strobe pulse width wrong");
  verify_after_a: assert property (@(posedge clk) disable iff (rst)
    $rose(program_strobe_n) |-> ##[1:VERIFY_WAIT] !output_gate_n) // RULE12
    else $error("no verify after program pulse");
  // a moving byte or address under the strobe would program the wrong cell
  data_hold_a: assert property (@(posedge clk) disable iff (rst)
    !program_strobe_n |-> !data_oe_n && $stable(data_out) &&
      $stable(mem_addr)) // RULE10 RULE11
    else $error("data or address moved under the strobe");
endmodule : uvc_host

// file: pkg/uvc_defines.svh
// timing counts and the pulse limit for the eprom host controller
//
// Function
// [RULE1] device drives data only when selected and gated
// [RULE2] address access equals select access delay
// [RULE3] data valid one gate delay after gate falls
// [RULE4] select high means standby, outputs floating
// [RULE5] releasing gate or select floats outputs
// [RULE6] host decodes select, gate tied to read
// [RULE7] program strobe ignored during read
// [RULE8] erased reads ones; programming only clears bits
// [RULE9] program mode: supply high and gate high
// [RULE10] programmer drives byte on data pins
// [RULE11] one strobe pulse per address, data stable
// [RULE12] repeat pulses and verify, give up after ten
// [RULE13] never hold program strobe statically low
// [RULE14] shared strobe programs identical parallel parts
// [RULE15] per-part select pulse programs different data
// [RULE16] select high during programming inhibits the part
// [RULE17] verify: select low, gate low, strobe high
// [RULE18] id read: high voltage line, low bit picks code
// [RULE19] supply and id high voltage are qualifier bits
`ifndef UVC_DEFINES_SVH
`define UVC_DEFINES_SVH
`define UVC_CLK_NS 40
`define UVC_ACC_NS 100
`define UVC_ACC_CYC ((`UVC_ACC_NS + `UVC_CLK_NS - 1) / `UVC_CLK_NS)
`define UVC_SETUP_NS 1000
`define UVC_SETUP_CYC ((`UVC_SETUP_NS + `UVC_CLK_NS - 1) / `UVC_CLK_NS)
`define UVC_PULSE_NS 50000
`define UVC_PULSE_CYC (`UVC_PULSE_NS / `UVC_CLK_NS)
`define UVC_MAX_PULSES 10
`endif

// file: pkg/uvc_pkg.sv
// types for the eprom host controller
package uvc_pkg;
  typedef enum logic [6:0] {
    UVC_IDLE = 7'h01,
    UVC_SETUP = 7'h02,
    UVC_READ = 7'h04,
    UVC_PULSE = 7'h08,
    UVC_GAP = 7'h10,
    UVC_VERIFY = 7'h20,
    UVC_DONE = 7'h40
  } uvc_state_e;
  typedef enum logic [1:0] {
    UVC_CMD_READ = 2'h0,
    UVC_CMD_PROG = 2'h1,
    UVC_CMD_ID = 2'h2
  } uvc_cmd_e;
endpackage : uvc_pkg

// file: verification/uvc_eprom_model.sv
// behavioural uv eprom answering the host controller pins
`timescale 1ns/100ps
module uvc_eprom_model #(
  parameter int ADDR_W = 8,
  parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0] PART = 8'ha5 // arbitrary value
) (
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic program_strobe_n,
  input wire logic prog_supply_hi,
  input wire logic id_highvolt_addr_line,
  input wire logic [7:0] host_data,
  input wire logic host_oe_n,
  input wire logic [3:0] needed,
  output logic [7:0] data_bus
);
  logic [7:0] mem [2**ADDR_W];
  logic [7:0] last;
  logic [3:0] hits;
  logic valid;
  wire drive = !chip_select_n && !output_gate_n;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    last = 8'h00;
    hits = 4'h0;
    valid = 1'b0;
  end
  // data lags select and gate by one access time
  always @(drive) begin
    valid = 1'b0;
    if (drive) valid <= #100 1'b1;
  end
  // a slow part needs several pulses; the count restarts per command
  always @(posedge chip_select_n) hits = 4'h0;
  // released bus shows the inverse of its last value, never a stale byte
  always @* begin
    if (!host_oe_n) data_bus = host_data;
    else if (drive && valid) begin
      data_bus = id_highvolt_addr_line ? (mem_addr[0] ? PART : MAKER) :
        mem[mem_addr];
      last = data_bus;
    end else data_bus = ~last;
  end
  // a pulse counts as it ends; cells only ever clear
  always @(posedge program_strobe_n) begin
    if (!chip_select_n && output_gate_n && prog_supply_hi) begin
      hits = hits + 4'h1;
      if (hits >= needed) mem[mem_addr] = mem[mem_addr] & host_data;
    end
  end
endmodule : uvc_eprom_model

// file: verification/uvc_host_bench.sv
// self-checking bench for the eprom host controller
`timescale 1ns/100ps
`include "uvc_defines.svh"
module uvc_host_bench;
  import uvc_pkg::*;
  localparam logic [7:0] MK = 8'h5a; // arbitrary value
  localparam logic [7:0] PT = 8'ha5; // arbitrary value
  logic clk, rst, req, busy, done, fail, cs_n, gate_n, strobe_n, vpp, idhv;
  logic oe_n;
  uvc_cmd_e cmd;
  logic [7:0] addr, maddr, a, wdata, rdata, din, dout, d;
  logic [7:0] shadow [256];
  logic [3:0] needed;
  int errors, compares, seed, pulses, k, n;
  uvc_host #(.ADDR_W(8), .SETUP_CYC(2), .PULSE_CYC(8), .ACC_CYC(3)) u_uvc_host (
    .clk(clk), .rst(rst), .req(req), .cmd(cmd), .addr(addr), .wdata(wdata),
    .busy(busy), .done(done), .fail(fail), .rdata(rdata), .mem_addr(maddr),
    .chip_select_n(cs_n), .output_gate_n(gate_n), .program_strobe_n(strobe_n),
    .prog_supply_hi(vpp), .id_highvolt_addr_line(idhv), .data_in(din),
    .data_out(dout), .data_oe_n(oe_n));
  uvc_eprom_model #(.ADDR_W(8), .MAKER(MK), .PART(PT)) u_uvc_eprom_model (
    .mem_addr(maddr), .chip_select_n(cs_n), .output_gate_n(gate_n),
    .program_strobe_n(strobe_n), .prog_supply_hi(vpp),
    .id_highvolt_addr_line(idhv), .host_data(dout), .host_oe_n(oe_n),
    .needed(needed), .data_bus(din));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // every pulse must come with raised supply and gate high
  always @(negedge strobe_n) begin
    pulses++;
    check({5'h0, cs_n, vpp, gate_n}, 8'h03);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic run(input uvc_cmd_e c, input logic [7:0] ad,
      input logic [7:0] wd);
    int i;
    @(negedge clk);
    req = 1'b1;
    cmd = c;
    addr = ad;
    wdata = wd;
    pulses = 0;
    @(negedge clk);
    req = 1'b0;
    check({7'h0, busy}, 8'h01);
    i = 0;
    while (done !== 1'b1 && i < 5000) begin
      @(negedge clk);
      i++;
    end
    if (i == 5000) begin
      errors++;
      $display("Error at %0t: no completion", $time);
      give_verdict();
    end
  endtask : run
  function automatic logic [7:0] id_code(input int low);
    return low[0] ? PT : MK;
  endfunction : id_code
  // {fail, pulses} a program command should report for a cell
  function automatic logic [7:0] prog_result(input logic [7:0] old,
      input logic [7:0] wd, input int need);
    if (old == wd) return 8'h01;
    if (need <= `UVC_MAX_PULSES && (old & wd) == wd) return {1'b0, 7'(need)};
    return {1'b1, 7'(`UVC_MAX_PULSES)};
  endfunction : prog_result
  initial begin
    rst = 1'b1;
    req = 1'b0;
    cmd = UVC_CMD_READ;
    addr = 8'h00;
    wdata = 8'h00;
    needed = 4'h1;
    errors = 0;
    compares = 0;
    pulses = 0;
    seed = 54504;
    foreach (shadow[i]) shadow[i] = 8'hff;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // random bytes, every third one over the previous address
    for (k = 0; k < 12; k++) begin
      if (k % 3 != 2) a = 8'($random(seed));
      d = 8'($random(seed));
      run(UVC_CMD_READ, a, 8'h00);
      check(rdata, shadow[a]);
      // a reprogrammed cell cannot regain ones, so its verify may give up
      run(UVC_CMD_PROG, a, d);
      check({fail, pulses[6:0]}, prog_result(shadow[a], d, 1));
      shadow[a] = shadow[a] & d;
      run(UVC_CMD_READ, a, 8'h00);
      check(rdata, shadow[a]);
    end
    $display("test random program done");
    // slow cells, the last limit and one beyond it
    for (k = 0; k < 3; k++) begin
      n = (k == 0) ? 4 : (k == 1) ? 10 : 15;
      needed = n[3:0];
      a = 8'hf0 + k[7:0];
      d = 8'($random(seed));
      run(UVC_CMD_PROG, a, d);
      check({fail, pulses[6:0]}, prog_result(shadow[a], d, n));
      if (n <= `UVC_MAX_PULSES) shadow[a] = shadow[a] & d;
      run(UVC_CMD_READ, a, 8'h00);
      check(rdata, shadow[a]);
    end
    $display("test pulse limit done");
    for (k = 0; k < 2; k++) begin
      run(UVC_CMD_ID, k[7:0], 8'h00);
      check(rdata, id_code(k));
    end
    $display("test id read done");
    give_verdict();
  end
endmodule : uvc_host_bench
